// ### oam_map.svh
// Constants for the OR/move/store/load execution datapath
// Assumes inclusion by bare name from the package and design files
`ifndef OAM_MAP_SVH
`define OAM_MAP_SVH
`define OAM_DATA_W 8
`define OAM_ADDR_W 7
`define OAM_REG_DEPTH 128
`define OAM_ACC_RST 8'h00
`define OAM_ZERO_RST 1'b0
`define OAM_ZERO_BYTE 8'h00
`define OAM_DEST_ACC 1'b0
`define OAM_DEST_REG 1'b1
`endif

// ### oam_pkg.sv
// Types for the OR/move/store/load execution datapath
// Assumes oam_map.svh is on the include path
`include "oam_map.svh"
package oam_pkg;
  typedef enum logic [2:0] {
    OAM_OP_IDLE = 3'b000,
    OAM_OP_OR = 3'b001,
    OAM_OP_MOVE = 3'b010,
    OAM_OP_STORE = 3'b011,
    OAM_OP_LOADI = 3'b100
  } oam_op_t;
endpackage

// ### oam_regfile.sv
// File register memory: one write port, one registered read port
// Assumes a single clock; read data appear one edge after the address
`timescale 1ns/1ps
`include "oam_map.svh"
module oam_regfile (
  input wire logic mclk,
  input wire logic ce,
  input wire logic rd_en,
  input wire logic [`OAM_ADDR_W-1:0] rd_addr,
  output logic [`OAM_DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [`OAM_ADDR_W-1:0] wr_addr,
  input wire logic [`OAM_DATA_W-1:0] wr_data
);
  logic [`OAM_DATA_W-1:0] mem [`OAM_REG_DEPTH];

  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ### oam_exec.sv
// Execution datapath for OR, move, store, immediate load and idle
// Assumes one instruction presented per issue pulse, synchronous to mclk
`timescale 1ns/1ps
`include "oam_map.svh"

module oam_exec
  import oam_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic issue,
  input wire oam_op_t op,
  input wire logic [`OAM_ADDR_W-1:0] reg_addr,
  input wire logic dest,
  input wire logic [`OAM_DATA_W-1:0] literal,
  output logic busy,
  output logic done,
  output logic [`OAM_DATA_W-1:0] acc,
  output logic zero_flag
);
  typedef enum logic [1:0] {
    OAM_ST_IDLE = 2'b00,
    OAM_ST_READ = 2'b01
  } oam_state_t;

  oam_state_t state;
  oam_op_t pend_op;
  logic [`OAM_ADDR_W-1:0] pend_addr;
  logic pend_dest;
  logic [`OAM_DATA_W-1:0] rd_data;
  logic [`OAM_DATA_W-1:0] result;
  logic rd_en;
  logic wr_en;
  logic [`OAM_ADDR_W-1:0] wr_addr;
  logic [`OAM_DATA_W-1:0] wr_data;
  logic take;
  logic needs_read;
  logic finish;

  ////////////////////////////////////////////////////////////////////
  // Issue and sequencing
  assign take = ce && issue && (state == OAM_ST_IDLE);
  assign needs_read = (op == OAM_OP_OR) || (op == OAM_OP_MOVE);
  assign rd_en = take && needs_read;
  assign finish = ce && (state == OAM_ST_READ);
  assign busy = (state != OAM_ST_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= OAM_ST_IDLE;
    end else if (ce) begin
      case (state)
        OAM_ST_IDLE: begin
          // Only OR and move need the read cycle
          if (take && needs_read) begin
            state <= OAM_ST_READ;
          end
        end
        default: begin
          state <= OAM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_op <= OAM_OP_IDLE;
      pend_addr <= '0;
      pend_dest <= `OAM_DEST_ACC;
    end else if (take) begin
      pend_op <= op;
      pend_addr <= reg_addr;
      pend_dest <= dest;
    end
  end

  // One-cycle pulse: the edge after take, or after the read cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= finish || (take && !needs_read);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result and register file write
  // Accumulator cannot move while busy, so the OR sees its value at issue
  always_comb begin
    if (pend_op == OAM_OP_OR) begin
      result = acc | rd_data;
    end else begin
      result = rd_data;
    end
  end

  // A store and a write-back never meet: nothing is taken while busy
  always_comb begin
    wr_en = 1'b0;
    wr_addr = reg_addr;
    wr_data = acc;
    if (take && (op == OAM_OP_STORE)) begin
      wr_en = 1'b1;
    end else if (finish && (pend_dest == `OAM_DEST_REG)) begin
      wr_en = 1'b1;
      wr_addr = pend_addr;
      wr_data = result;
    end
  end

  // Read launched on the issue edge; data stand in the finish cycle
  oam_regfile u_regfile (
    .mclk(mclk),
    .ce(ce),
    .rd_en(rd_en),
    .rd_addr(reg_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Accumulator and zero flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= `OAM_ACC_RST;
    end else if (take && (op == OAM_OP_LOADI)) begin
      acc <= literal;
    end else if (finish && (pend_dest == `OAM_DEST_ACC)) begin
      acc <= result;
    end
  end

  // Store, load and idle leave the flag alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zero_flag <= `OAM_ZERO_RST;
    end else if (finish) begin
      zero_flag <= (result == `OAM_ZERO_BYTE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Instruction results
  a_or_to_acc: assert property (finish && pend_op == OAM_OP_OR && !pend_dest
      |=> acc == ($past(acc) | $past(rd_data)))
    else $error("OR result not in accumulator");
  a_or_zero: assert property (finish && pend_op == OAM_OP_OR
      |=> zero_flag == (($past(acc) | $past(rd_data)) == `OAM_ZERO_BYTE))
    else $error("Zero flag wrong after OR");
  a_or_to_reg: assert property (finish && pend_op == OAM_OP_OR && pend_dest
      |-> wr_en && wr_addr == pend_addr ##1 $stable(acc))
    else $error("OR with dest 1 mishandled");
  a_move_acc: assert property (finish && pend_op == OAM_OP_MOVE && !pend_dest
      |=> acc == $past(rd_data))
    else $error("Move did not load accumulator");
  a_move_test: assert property (finish && pend_op == OAM_OP_MOVE && pend_dest
      |-> wr_data == rd_data ##1 zero_flag == ($past(rd_data) == `OAM_ZERO_BYTE))
    else $error("Move test altered data or flag");
  a_store_write: assert property (take && op == OAM_OP_STORE
      |-> wr_en && wr_data == acc ##1 $stable(acc) && $stable(zero_flag) && done)
    else $error("Store misbehaved");
  a_load_imm: assert property (take && op == OAM_OP_LOADI
      |=> acc == $past(literal) && $stable(zero_flag) && done)
    else $error("Immediate load misbehaved");
  a_idle_quiet: assert property (take && op == OAM_OP_IDLE
      |-> !wr_en ##1 $stable(acc) && $stable(zero_flag) && done)
    else $error("Idle changed state");
  a_or_reg_data: assert property (finish && pend_op == OAM_OP_OR && pend_dest
      |-> wr_data == (acc | rd_data))
    else $error("OR result not written back");
  a_or_acc_nowr: assert property (finish && pend_op == OAM_OP_OR && !pend_dest
      |-> !wr_en)
    else $error("OR with dest 0 wrote a register");
  a_move_zero: assert property (finish && pend_op == OAM_OP_MOVE && !pend_dest
      |=> zero_flag == ($past(rd_data) == `OAM_ZERO_BYTE))
    else $error("Zero flag wrong after move");
  a_move_rewrite: assert property (finish && pend_op == OAM_OP_MOVE && pend_dest
      |-> wr_en && wr_addr == pend_addr ##1 $stable(acc))
    else $error("Move test did not rewrite in place");
  a_store_addr: assert property (take && op == OAM_OP_STORE
      |-> wr_addr == reg_addr && !rd_en)
    else $error("Store hit the wrong register");
  a_load_quiet: assert property (take && op == OAM_OP_LOADI
      |-> !wr_en && !rd_en)
    else $error("Immediate load touched the register file");

  // Sequencing and clock enable
  a_read_len: assert property (take && needs_read ##1 ce
      |-> busy ##1 !busy && done)
    else $error("Read op not two cycles");
  a_finish_done: assert property (finish
      |=> done && !busy)
    else $error("Read op did not complete");
  a_busy_hold: assert property (busy && issue
      |=> $stable(pend_addr) && $stable(pend_dest))
    else $error("Request taken while busy");
  a_no_stray_wr: assert property (!take && !finish
      |-> !wr_en)
    else $error("Register written with no instruction");
  a_ce_freeze: assert property (!ce
      |=> $stable(acc) && $stable(zero_flag) && $stable(state) && $stable(done))
    else $error("State moved while clock enable low");

  // Main scenarios
  c_or_reg: cover property (finish && pend_op == OAM_OP_OR && pend_dest);
  c_move_zero: cover property (finish && pend_op == OAM_OP_MOVE ##1 zero_flag);
  c_store: cover property (take && op == OAM_OP_STORE);
  c_load: cover property (take && op == OAM_OP_LOADI ##1 take);
  c_ce_stall: cover property (busy && !ce);
endmodule

// ### tb_or_and_move_instr_exec.sv
// Self-checking bench for the OR/move/store/load execution datapath
// Assumes oam_pkg and oam_map.svh are compiled first; inputs change on the falling edge
`timescale 1ns/1ps
`include "oam_map.svh"
module tb_or_and_move_instr_exec
  import oam_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic issue = 1'b0;
  oam_op_t op = OAM_OP_IDLE;
  logic [`OAM_ADDR_W-1:0] reg_addr = 7'h00;
  logic dest = 1'b0;
  logic [`OAM_DATA_W-1:0] literal = 8'h00;
  logic busy;
  logic done;
  logic [`OAM_DATA_W-1:0] acc;
  logic zero_flag;
  int fails = 0;
  int checked = 0;

  always #4 mclk = ~mclk;

  oam_exec uut (
    .mclk(mclk), .rst(rst), .ce(ce), .issue(issue), .op(op), .reg_addr(reg_addr),
    .dest(dest), .literal(literal), .busy(busy), .done(done), .acc(acc),
    .zero_flag(zero_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Issue one instruction, wait for done, then check latency, acc and zero flag
  task automatic do_op(input oam_op_t o, input logic [6:0] a, input logic d,
                       input logic [7:0] l, input logic [7:0] ea, input logic ez);
    int n;
    @(negedge mclk);
    op = o;
    reg_addr = a;
    dest = d;
    literal = l;
    issue = 1'b1;
    @(negedge mclk);
    issue = 1'b0;
    n = 1;
    chk({15'h0000, busy}, {15'h0000, (o == OAM_OP_OR || o == OAM_OP_MOVE)});
    while (done !== 1'b1 && n < 6) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n), (o == OAM_OP_OR || o == OAM_OP_MOVE) ? 16'h0002 : 16'h0001);
    chk({7'h00, zero_flag, acc}, {7'h00, ez, ea});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 3000);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    chk({7'h00, zero_flag, acc}, {7'h00, `OAM_ZERO_RST, `OAM_ACC_RST});
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h5a, 8'h5a, 1'b0);
    do_op(OAM_OP_STORE, 7'h7f, 1'b0, 8'h00, 8'h5a, 1'b0);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    do_op(OAM_OP_MOVE, 7'h7f, 1'b0, 8'h00, 8'h5a, 1'b0);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    do_op(OAM_OP_STORE, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h81, 8'h81, 1'b0);
    do_op(OAM_OP_MOVE, 7'h00, 1'b1, 8'h00, 8'h81, 1'b1);
    do_op(OAM_OP_MOVE, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h24, 8'h24, 1'b1);
    do_op(OAM_OP_OR, 7'h7f, 1'b0, 8'h00, 8'h7e, 1'b0);
    do_op(OAM_OP_OR, 7'h00, 1'b1, 8'h00, 8'h7e, 1'b0);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    do_op(OAM_OP_MOVE, 7'h00, 1'b0, 8'h00, 8'h7e, 1'b0);
    do_op(OAM_OP_MOVE, 7'h7f, 1'b1, 8'h00, 8'h7e, 1'b0);
    do_op(OAM_OP_MOVE, 7'h7f, 1'b0, 8'h00, 8'h5a, 1'b0);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    do_op(OAM_OP_STORE, 7'h05, 1'b0, 8'hff, 8'h00, 1'b0);
    do_op(OAM_OP_OR, 7'h05, 1'b0, 8'h00, 8'h00, 1'b1);
    do_op(OAM_OP_IDLE, 7'h05, 1'b1, 8'hff, 8'h00, 1'b1);
    do_op(OAM_OP_LOADI, 7'h00, 1'b0, 8'hff, 8'hff, 1'b1);
    do_op(OAM_OP_IDLE, 7'h7f, 1'b0, 8'h00, 8'hff, 1'b1);
    // Clock enable low freezes a waiting load, then a move in its read cycle
    @(negedge mclk);
    ce = 1'b0;
    op = OAM_OP_LOADI;
    literal = 8'h3c;
    issue = 1'b1;
    repeat (2) @(negedge mclk);
    chk({zero_flag, busy, done, 5'h00, acc}, {1'b1, 1'b0, 1'b0, 5'h00, 8'hff});
    ce = 1'b1;
    @(negedge mclk);
    chk({zero_flag, busy, done, 5'h00, acc}, {1'b1, 1'b0, 1'b1, 5'h00, 8'h3c});
    op = OAM_OP_MOVE;
    reg_addr = 7'h7f;
    dest = 1'b0;
    @(negedge mclk);
    ce = 1'b0;
    repeat (2) @(negedge mclk);
    chk({zero_flag, busy, done, 5'h00, acc}, {1'b1, 1'b1, 1'b0, 5'h00, 8'h3c});
    ce = 1'b1;
    @(negedge mclk);
    issue = 1'b0;
    chk({zero_flag, busy, done, 5'h00, acc}, {1'b0, 1'b0, 1'b1, 5'h00, 8'h5a});
    // Reset in mid-run clears the datapath but keeps the file registers
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk({14'h0000, busy, done}, 16'h0000);
    rst = 1'b0;
    chk({7'h00, zero_flag, acc}, {7'h00, `OAM_ZERO_RST, `OAM_ACC_RST});
    do_op(OAM_OP_MOVE, 7'h05, 1'b0, 8'h00, 8'h00, 1'b1);
    tally_and_finish();
  end
endmodule
